/* rtl/rate_pin_params.svh */
// Register indices, field positions and reset values of the
// audio rate and timing pin routing register slice.
// Assumes word addressing: byte address is four times the index.
`ifndef RATE_PIN_PARAMS_SVH
`define RATE_PIN_PARAMS_SVH

// Register indices (byte address = index * 4)
`define IDX_RATE_B   8'h40
`define IDX_RATE_C   8'h41
`define IDX_RESERVED_SLOT     8'h42
`define IDX_PIN1     8'h43
`define IDX_PIN2     8'h44
`define IDX_PIN3     8'h45
`define IDX_PIN4     8'h46
`define IDX_STATUS   8'h60

// Field positions
`define RATE_MSB     2
`define SEL_MSB      3
`define DRIVE_BIT    4
`define STAT_LVL_MSB 3
`define STAT_ALT_B   4
`define STAT_ALT_C   5

// Reset values
`define RST_RATE     3'h0
`define RST_SEL1     4'h1
`define RST_SEL2     4'h2
`define RST_SEL3     4'h3
`define RST_SEL4     4'h4
`define RST_DRIVE    1'b0

`endif

/* rtl/rate_pin_pkg.sv */
// Types shared by the audio rate and timing pin routing block.
// Assumes nothing of its surroundings.
package rate_pin_pkg;

    // Audio clock multiple of the base sample rate
    typedef enum logic [2:0] {
        RATE_512  = 3'h0,
        RATE_384  = 3'h1,
        RATE_256  = 3'h2,
        RATE_192  = 3'h3,
        RATE_128  = 3'h4,
        RATE_64   = 3'h5,
        RATE_1    = 3'h6,
        RATE_ZBIT = 3'h7
    } rate_mult_t;

    // One timing pin routing word, bit 4 drive, bits 3..0 source
    typedef struct packed {
        logic       hi_drive;
        logic [3:0] sel;
    } pin_route_t;

endpackage

/* rtl/reg_bus_if.sv */
// Internal register access path between the bus front end and the
// register bank. Single clock; all signals are on mclk.
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
    logic        wr_en;   // Write strobe, one cycle
    logic [7:0]  wr_idx;  // Write register index
    logic [15:0] wr_data; // Write data
    logic        rd_en;   // Read strobe, address phase
    logic [7:0]  rd_idx;  // Read register index
    logic [15:0] rd_data; // Read data, combinational

    modport port (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
    modport regs (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
endinterface
`default_nettype wire

/* rtl/ahb_reg_port.sv */
// AHB-Lite slave front end for the register bank, zero wait states.
// Assumes one master, word transfers only, all inputs on mclk.
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Register side
    reg_bus_if.port          bus
);
    // Word-aligned, word-sized access inside the 256-word window
    function automatic logic addr_ok(input logic [31:0] a, input logic [2:0] s);
        addr_ok = (a[31:10] == 22'h0) && (a[1:0] == 2'h0) && (s == 3'h2);
    endfunction

    logic       accept;    // Address phase taken this edge
    logic       wr_pend_q; // Write data phase pending
    logic [7:0] wr_idx_q;  // Index of pending write
    logic [31:0] hrdata_q; // Registered read data
    logic       ready_q;   // Ready response

    assign accept = hsel && htrans[1] && hready;

    // Requests to the bank
    assign bus.rd_en   = accept && !hwrite && addr_ok(haddr, hsize);
    assign bus.rd_idx  = haddr[9:2];
    assign bus.wr_en   = wr_pend_q;
    assign bus.wr_idx  = wr_idx_q;
    assign bus.wr_data = hwdata[15:0];

    // Write address phase capture
    always_ff @(posedge mclk or posedge reset)
        if (reset)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h0;
        end
        else if (ce)
        begin
            wr_pend_q <= accept && hwrite && addr_ok(haddr, hsize);
            wr_idx_q  <= haddr[9:2];
        end

    // Read data, zero for unmapped or refused accesses
    always_ff @(posedge mclk or posedge reset)
        if (reset)
            hrdata_q <= 32'h0;
        else if (ce && accept)
            hrdata_q <= bus.rd_en ? {16'h0, bus.rd_data} : 32'h0;

    // Always ready, always OKAY
    always_ff @(posedge mclk or posedge reset)
        if (reset)
            ready_q <= 1'b1;
        else if (ce)
            ready_q <= 1'b1;

    assign hrdata    = hrdata_q;
    assign hreadyout = ready_q;
    assign hresp     = 1'b0;
endmodule
`default_nettype wire

/* rtl/timing_pin_mux.sv */
// Routes one of the timing sources to each timing output pin and
// carries the drive strength choice out. Outputs are registered.
// Assumes timing sources come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module timing_pin_mux #(
    parameter int PINS  = 4,
    parameter int SRC_W = 16
) (
    // Clock, reset, enable
    input  wire logic                     mclk,
    input  wire logic                     reset,
    input  wire logic                     ce,
    // Sources and routing
    input  wire logic [SRC_W-1:0]         timing_src,
    input  wire rate_pin_pkg::pin_route_t route [PINS],
    // Pin outputs
    output logic      [PINS-1:0]          pin_level,
    output logic      [PINS-1:0]          pin_hi_drive
);
    import rate_pin_pkg::*;

    // Registered selection per pin
    always_ff @(posedge mclk or posedge reset)
        if (reset)
        begin
            pin_level    <= '0;
            pin_hi_drive <= '0;
        end
        else if (ce)
        begin
            for (int i = 0; i < PINS; i++)
            begin
                pin_level[i]    <= timing_src[route[i].sel];
                pin_hi_drive[i] <= route[i].hi_drive;
            end
        end
endmodule
`default_nettype wire

/* rtl/audio_rate_timing_regs.sv */
// Audio clock rate selectors and timing pin routing registers,
// reached over AHB-Lite, with the timing output pin multiplexer.
// Assumes one clock, timing sources on mclk, a single bus master.
`timescale 1ns/1ps
`default_nettype none
`include "rate_pin_params.svh"
module audio_rate_timing_regs #(
    parameter int SRC_W = 16
) (
    // Clock, reset, enable
    input  wire logic                    mclk,
    input  wire logic                    reset,
    input  wire logic                    ce,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // Timing sources from the video timing logic
    input  wire logic [SRC_W-1:0]        timing_src,
    // Audio clock rate selections
    output rate_pin_pkg::rate_mult_t     audio_clock_out_b_rate,
    output rate_pin_pkg::rate_mult_t     audio_clock_out_c_rate,
    output logic                         audio_clock_out_b_alt,
    output logic                         audio_clock_out_c_alt,
    // Timing output pins
    output logic      [3:0]              timing_out,
    output logic      [3:0]              timing_hi_drive
);
    import rate_pin_pkg::*;

    localparam int PINS = 4;

    // Rate multiples that need the alternate reference mode
    function automatic logic needs_alt(input rate_mult_t r);
        needs_alt = (r == RATE_384) || (r == RATE_192);
    endfunction

    // Strip unused bits from a written rate word
    function automatic rate_mult_t rate_of(input logic [15:0] w);
        rate_of = rate_mult_t'(w[`RATE_MSB:0]);
    endfunction

    // Register access path
    reg_bus_if bus ();

    // Rate selector registers
    rate_mult_t rate_b_q;      // Output b multiple
    rate_mult_t rate_b_d;      // Next value
    rate_mult_t rate_c_q;      // Output c multiple
    rate_mult_t rate_c_d;      // Next value

    // Routing registers, one per pin
    pin_route_t route_q [PINS]; // Current routing
    pin_route_t route_d [PINS]; // Next routing

    // Alternate reference flags
    logic alt_b_q;             // Output b needs alternate mode
    logic alt_c_q;             // Output c needs alternate mode

    // Read data assembly
    logic [15:0] rd_word;      // Selected register word

    // Bus front end
    ahb_reg_port u_port (
        .mclk      (mclk),
        .reset     (reset),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .bus       (bus)
    );

    // Next value of the rate selectors
    always_comb
    begin
        rate_b_d = rate_b_q;
        rate_c_d = rate_c_q;
        // Write to output b rate
        if (bus.wr_en && bus.wr_idx == `IDX_RATE_B)
            rate_b_d = rate_of(bus.wr_data);
        // Write to output c rate
        if (bus.wr_en && bus.wr_idx == `IDX_RATE_C)
            rate_c_d = rate_of(bus.wr_data);
    end

    // Rate selector state
    always_ff @(posedge mclk or posedge reset)
        if (reset)
        begin
            rate_b_q <= rate_mult_t'(`RST_RATE);
            rate_c_q <= rate_mult_t'(`RST_RATE);
        end
        else if (ce)
        begin
            rate_b_q <= rate_b_d;
            rate_c_q <= rate_c_d;
        end

    // Alternate mode flags follow the rate selectors
    always_ff @(posedge mclk or posedge reset)
        if (reset)
        begin
            alt_b_q <= 1'b0;
            alt_c_q <= 1'b0;
        end
        else if (ce)
        begin
            alt_b_q <= needs_alt(rate_b_d);
            alt_c_q <= needs_alt(rate_c_d);
        end

    // Next value of the routing registers
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
        begin
            route_d[i] = route_q[i];
            // Only bits 4..0 are kept
            if (bus.wr_en && bus.wr_idx == 8'(`IDX_PIN1 + i))
            begin
                route_d[i].sel      = bus.wr_data[`SEL_MSB:0];
                route_d[i].hi_drive = bus.wr_data[`DRIVE_BIT];
            end
        end
    end

    // Routing state with per-pin defaults
    always_ff @(posedge mclk or posedge reset)
        if (reset)
        begin
            route_q[0] <= '{hi_drive: `RST_DRIVE, sel: `RST_SEL1};
            route_q[1] <= '{hi_drive: `RST_DRIVE, sel: `RST_SEL2};
            route_q[2] <= '{hi_drive: `RST_DRIVE, sel: `RST_SEL3};
            route_q[3] <= '{hi_drive: `RST_DRIVE, sel: `RST_SEL4};
        end
        else if (ce)
        begin
            route_q <= route_d;
        end

    // Read mux over next values of the rate and routing words, so a read right after a write sees it
    always_comb
    begin
        rd_word = 16'h0;
        unique case (bus.rd_idx)
            // Rate selectors, upper bits read zero
            `IDX_RATE_B: rd_word = {13'h0, rate_b_d};
            `IDX_RATE_C: rd_word = {13'h0, rate_c_d};
            // Routing words, upper bits read zero
            `IDX_PIN1:   rd_word = {11'h0, route_d[0]};
            `IDX_PIN2:   rd_word = {11'h0, route_d[1]};
            `IDX_PIN3:   rd_word = {11'h0, route_d[2]};
            `IDX_PIN4:   rd_word = {11'h0, route_d[3]};
            // Live pin levels and alternate mode flags
            `IDX_STATUS: rd_word = {10'h0, alt_c_q, alt_b_q, timing_out};
            // Reserved slot and unmapped indices
            default:     rd_word = 16'h0;
        endcase
    end

    assign bus.rd_data = rd_word;

    // Timing pin multiplexer
    timing_pin_mux #(
        .PINS  (PINS),
        .SRC_W (SRC_W)
    ) u_mux (
        .mclk         (mclk),
        .reset        (reset),
        .ce           (ce),
        .timing_src   (timing_src),
        .route        (route_q),
        .pin_level    (timing_out),
        .pin_hi_drive (timing_hi_drive)
    );

    // Rate outputs straight from their registers
    assign audio_clock_out_b_rate = rate_b_q;
    assign audio_clock_out_c_rate = rate_c_q;
    assign audio_clock_out_b_alt  = alt_b_q;
    assign audio_clock_out_c_alt  = alt_c_q;

    // Helper views for the checks below
    logic [2:0] wr_rate;       // Written rate field
    logic [3:0] wr_sel;        // Written route select
    logic       wr_drive;      // Written drive bit
    assign wr_rate  = bus.wr_data[`RATE_MSB:0];
    assign wr_sel   = bus.wr_data[`SEL_MSB:0];
    assign wr_drive = bus.wr_data[`DRIVE_BIT];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // Write to output b rate lands one edge later
    a_rate_b_write: assert property (
        ce && bus.wr_en && bus.wr_idx == `IDX_RATE_B
        |=> rate_b_q == $past(wr_rate))
        else $error("output b rate not updated");

    // Write to output c rate lands one edge later
    a_rate_c_write: assert property (
        ce && bus.wr_en && bus.wr_idx == `IDX_RATE_C
        |=> rate_c_q == $past(wr_rate) && rate_b_q == $past(rate_b_q))
        else $error("output c rate not updated");

    // Both rates come out of reset at zero
    a_rate_reset_val: assert property (
        $past(reset) |-> rate_b_q == RATE_512 && rate_c_q == RATE_512)
        else $error("rate reset value wrong");

    // Pin 1 default source
    a_pin1_reset: assert property (
        $past(reset) |-> route_q[0].sel == 4'h1)
        else $error("pin 1 default wrong");

    // Pin 2 default source
    a_pin2_reset: assert property (
        $past(reset) |-> route_q[1].sel == 4'h2)
        else $error("pin 2 default wrong");

    // Pin 3 default source
    a_pin3_reset: assert property (
        $past(reset) |-> route_q[2].sel == 4'h3)
        else $error("pin 3 default wrong");

    // Pin 4 default source and pin 1 drive low
    a_pin4_reset: assert property (
        $past(reset) |-> route_q[3].sel == 4'h4 && route_q[0].hi_drive == 1'b0)
        else $error("pin 4 default wrong");

    // Pin route write reaches the pin two edges later
    a_route_to_pin: assert property (
        ce && bus.wr_en && bus.wr_idx == `IDX_PIN3 ##1 ce[*1] ##1 ce
        |-> timing_out[2] == $past(timing_src[route_q[2].sel]))
        else $error("pin 3 not routed");

    // Drive bit write reaches the drive output two edges later
    a_drive_write: assert property (
        ce && bus.wr_en && bus.wr_idx == `IDX_PIN1 ##1 ce
        |=> timing_hi_drive[0] == $past(wr_drive, 2))
        else $error("drive strength not applied");

    // 384x code decodes as listed and sets the alternate flag
    a_rate_decode: assert property (
        ce && bus.wr_en && bus.wr_idx == `IDX_RATE_B && wr_rate == 3'h1
        |=> audio_clock_out_b_alt && rate_b_q == RATE_384)
        else $error("rate code decode wrong");

    // Clock enable low freezes the pin registers for that edge
    a_ce_freeze: assert property (
        !ce
        |=> timing_out == $past(timing_out) && timing_hi_drive == $past(timing_hi_drive))
        else $error("pins moved while clock enable low");

    // Main scenarios
    c_write_384: cover property (ce && bus.wr_en && bus.wr_idx == `IDX_RATE_C && wr_rate == 3'h1);
    c_write_route: cover property (ce && bus.wr_en && bus.wr_idx == `IDX_PIN4 && wr_sel == 4'h9);
    c_read_status: cover property (bus.rd_en && bus.rd_idx == `IDX_STATUS && timing_out != 4'h0);
    c_high_drive: cover property (timing_hi_drive == 4'hf);
endmodule
`default_nettype wire

/* tb/timing_src_model.sv */
// Model of the video timing logic that feeds the timing sources.
// Assumes one clock, mclk; sources move on every rising edge.
`timescale 1ns/1ps
`default_nettype none
module timing_src_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Timing sources towards the block
    output logic      [15:0] timing_src
);
    // Shift pattern, so every source toggles often and no bit sits still
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
            timing_src <= 16'ha5c3;
        else
            timing_src <= {timing_src[14:0], timing_src[15] ^ timing_src[13] ^ timing_src[12] ^ timing_src[10]};
    end
endmodule
`default_nettype wire

/* tb/audio_rate_and_timing_pin_select_test.sv */
// Self-checking bench for the audio rate and timing pin registers.
// Assumes a single AHB-Lite master and the source model on mclk.
`timescale 1ns/1ps
`default_nettype none
module audio_rate_and_timing_pin_select_test;
    import rate_pin_pkg::*;
    logic        mclk = 1'b0;       // Bus clock, 20 ns
    logic        reset = 1'b1;      // Active high reset
    logic        ce = 1'b1;         // Clock enable, high except during the hold test
    logic        hsel = 1'b0;       // Bus select
    logic [31:0] haddr = 32'h0;     // Bus address
    logic [1:0]  htrans = 2'h0;     // Transfer type
    logic        hwrite = 1'b0;     // Write flag
    logic [2:0]  hsize = 3'h2;      // Word size
    logic [31:0] hwdata = 32'h0;    // Write data
    logic [31:0] hrdata;            // Read data
    logic        hreadyout;         // Slave ready, also bus ready
    logic        hresp;             // Response
    logic [15:0] timing_src;        // Sources from the model
    logic [15:0] src_hist;          // Sources as seen before the edge
    rate_mult_t  rate_b;            // Output b multiple
    rate_mult_t  rate_c;            // Output c multiple
    logic        alt_b;             // Output b control hint
    logic        alt_c;             // Output c control hint
    logic [3:0]  timing_out;        // Pin levels
    logic [3:0]  timing_hi_drive;   // Pin drive strengths
    logic [4:0]  exp_route [4];     // Expected routing words
    int          failures = 0;      // Mismatch count
    int          n_checks = 0;      // Comparison count
    logic [31:0] rd;                // Last read word
    logic [2:0]  code;              // Random rate code
    logic [4:0]  rw;                // Random routing word
    int          pin;               // Random pin index
    logic [3:0]  snap;              // Pin levels frozen by clock enable

    // Clock
    always #10 mclk = ~mclk;

    // Far side source model
    timing_src_model i_src (.mclk(mclk), .reset(reset), .timing_src(timing_src));

    // Device under test
    audio_rate_timing_regs i_dut (
        .mclk(mclk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .timing_src(timing_src),
        .audio_clock_out_b_rate(rate_b), .audio_clock_out_c_rate(rate_c),
        .audio_clock_out_b_alt(alt_b), .audio_clock_out_c_alt(alt_c),
        .timing_out(timing_out), .timing_hi_drive(timing_hi_drive));

    // Source values from before each edge, for the one-edge latency
    always @(posedge mclk)
    begin
        src_hist <= timing_src;
    end

    // Expected control hint for a rate code
    function automatic logic f_alt(input logic [2:0] c);
        return (c == 3'h1) || (c == 3'h3);
    endfunction

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic print_verdict();
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Wait for ready sampled high at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1)
            chk(32'h0, 32'h1);
    endtask

    // One single word transfer; read data returned in rd
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        wait_ready();
        rd = hrdata;
    endtask

    // Reset held six cycles, released after an edge
    task automatic do_reset();
        reset <= 1'b1;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++)
            exp_route[i] = {1'b0, 4'(i + 1)};
        @(posedge mclk);
    endtask

    // Pins follow the routed source, drive follows bit 4
    task automatic check_pins(input int n);
        repeat (n)
        begin
            @(negedge mclk);
            for (int i = 0; i < 4; i++)
            begin
                chk(timing_out[i], src_hist[exp_route[i][3:0]]);
                chk(timing_hi_drive[i], exp_route[i][4]);
            end
        end
    endtask

    // Register defaults read back over the bus
    task automatic check_defaults();
        xfer(1'b0, `IDX_RATE_B, 16'h0);
        chk(rd, 32'h0);
        xfer(1'b0, `IDX_RATE_C, 16'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b0, 8'(`IDX_PIN1 + i), 16'h0);
            chk(rd, 32'(i + 1));
        end
        check_pins(3);
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(82156));
        do_reset();
        check_defaults();
        // Every rate code on both outputs, upper bits written zero
        for (int c = 0; c < 8; c++)
        begin
            xfer(1'b1, `IDX_RATE_B, {13'h0, 3'(c)});
            xfer(1'b1, `IDX_RATE_C, {13'h0, 3'(7 - c)});
            xfer(1'b0, `IDX_RATE_B, 16'h0);
            chk(rd, 32'(c));
            xfer(1'b0, `IDX_RATE_C, 16'h0);
            chk(rd, 32'(7 - c));
            @(negedge mclk);
            chk(rate_b, 32'(c));
            chk(rate_c, 32'(7 - c));
            chk(alt_b, f_alt(3'(c)));
            chk(alt_c, f_alt(3'(7 - c)));
        end
        // Routing words, four fixed with drive high then random, each read back at once
        for (int k = 0; k < 24; k++)
        begin
            pin = $urandom_range(3, 0);
            rw = 5'($urandom_range(31, 0));
            if (k < 4)
                rw = {1'b1, 4'(k * 5)};
            xfer(1'b1, 8'(`IDX_PIN1 + pin), {11'h0, rw});
            exp_route[pin] = rw;
            xfer(1'b0, 8'(`IDX_PIN1 + pin), 16'h0);
            chk(rd, {27'h0, rw});
            check_pins(3);
        end
        // Reserved and unmapped places read zero, write has no effect
        xfer(1'b1, `IDX_RESERVED_SLOT, 16'hffff);
        xfer(1'b0, `IDX_RESERVED_SLOT, 16'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 8'h7f, 16'h0);
        chk(rd, 32'h0);
        chk(hresp, 32'h0);
        // Clock enable low holds the pins still, then they follow again
        @(posedge mclk);
        ce <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        snap = timing_out;
        repeat (3)
        begin
            @(negedge mclk);
            chk(timing_out, snap);
        end
        @(posedge mclk);
        ce <= 1'b1;
        @(posedge mclk);
        check_pins(3);
        // Second reset restores every default
        do_reset();
        check_defaults();
        print_verdict();
    end

    // Watchdog, far beyond the expected run length
    initial
    begin
        #(20 * 20000);
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
